// >>> hw/vomec_pkg.sv
/*
 Constants, register map and carrier types of the vector operand, mask and
 element control block. Assumes one 20 MHz core clock and an AHB-Lite bus.
*/
package vomec_pkg;
   localparam int REG_BITS = 128;
   localparam int IDX_W = 16;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_START = 8'h04;
   localparam logic [7:0] OFS_LEN = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_ILLCNT = 8'h10;
   localparam int CTRL_GMUL_LSB = 0;
   localparam int CTRL_SELW_LSB = 3;
   localparam int CTRL_TA_BIT = 6;
   localparam int CTRL_MA_BIT = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [IDX_W-1:0] START_RST = 16'h0000;
   localparam logic [IDX_W-1:0] LEN_RST = 16'h0000;
   localparam logic [31:0] ILLCNT_RST = 32'h0000_0000;
   localparam logic [2:0] GMUL_RSVD = 3'h4;
   localparam logic [2:0] SELW_CODE_MAX = 3'h3;
   localparam logic [2:0] SELW_BASE_LOG = 3'h3;
   localparam logic [2:0] MASK_OPW_LOG = 3'h0;
   localparam logic signed [3:0] MAX_GROUP_LOG = 4'sh3;
   localparam int MASK_FIELD_BIT = 25;
   localparam int VD_LSB = 7;
   localparam int VS1_LSB = 15;
   localparam int VS2_LSB = 20;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam int CAUSE_W = 6;

   typedef enum logic [2:0] {
      OPK_PLAIN, OPK_WIDEN, OPK_NARROW, OPK_WRED, OPK_MASKDST, OPK_SCALARDST
   } vomec_opk_t;

   typedef enum logic [2:0] {
      CLS_PRESTART, CLS_ACTIVE, CLS_INACTIVE, CLS_TAIL, CLS_BEYOND
   } vomec_cls_t;

   typedef struct packed {
      logic valid;
      logic [31:0] word;
      vomec_opk_t opk;
      logic vd_vec;
      logic [1:0] src_vec;
      logic [1:0] src_mask;
      logic writes_xf;
   } vomec_inst_t;

   typedef struct packed {
      logic valid;
      logic illegal;
      logic [CAUSE_W-1:0] cause;
      logic masked;
      logic tail_agn;
      logic mask_agn;
      logic mask_dst;
      logic scal_dst;
      logic xf_write;
   } vomec_dec_t;

   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
      logic mask_bit;
      logic mask_load;
   } vomec_elem_req_t;

   typedef struct packed {
      logic valid;
      vomec_cls_t cls;
      logic write_en;
      logic write_ones;
      logic write_result;
      logic exc_en;
   } vomec_elem_res_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } vomec_ahb_req_t;
endpackage : vomec_pkg

// >>> hw/vomec_ctrl.sv
/*
 Vector operand legality decoder and per-element write/exception control,
 with its configuration registers behind an AHB-Lite slave.
 Assumes decode and element requests come from logic on the same clock.
*/
`timescale 1ns/100ps
module vomec_ctrl (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire vomec_pkg::vomec_ahb_req_t ahb_i,
   input wire logic [31:0] hwdata_i,
   input wire vomec_pkg::vomec_inst_t inst_i,
   input wire vomec_pkg::vomec_elem_req_t elem_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output vomec_pkg::vomec_dec_t dec_o,
   output vomec_pkg::vomec_elem_res_t elem_o
);
   import vomec_pkg::*;

   function automatic logic [4:0] grp_n(input logic signed [3:0] e);
      grp_n = (e > 4'sh0) ? (5'h1 << e[2:0]) : 5'h1;
   endfunction : grp_n

   function automatic logic ovl(input logic [4:0] a, input logic [4:0] na,
                                input logic [4:0] b, input logic [4:0] nb);
      ovl = ({1'b0, a} < ({1'b0, b} + {1'b0, nb})) && ({1'b0, b} < ({1'b0, a} + {1'b0, na}));
   endfunction : ovl

   function automatic logic misal(input logic [4:0] r, input logic signed [3:0] e);
      misal = (e > 4'sh0) && ((r & (grp_n(e) - 5'h1)) != 5'h0);
   endfunction : misal

   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [IDX_W-1:0] start_reg;
   logic [IDX_W-1:0] start_next;
   logic [IDX_W-1:0] len_reg;
   logic [IDX_W-1:0] len_next;
   logic [31:0] illcnt_reg;
   logic [31:0] illcnt_next;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   vomec_dec_t dec_reg;
   vomec_dec_t dec_next;
   vomec_elem_res_t elem_reg;
   vomec_elem_res_t elem_next;

   // Configuration fields
   wire [2:0] gmul_code = ctrl_reg[CTRL_GMUL_LSB +: 3];
   wire [2:0] selw_code = ctrl_reg[CTRL_SELW_LSB +: 3];
   wire cfg_bad = (gmul_code == GMUL_RSVD) || (selw_code > SELW_CODE_MAX);
   wire signed [3:0] gmul_log = $signed({gmul_code[2], gmul_code});
   wire [2:0] selw_log = 3'(selw_code + SELW_BASE_LOG);
   wire [2:0] wselw_log = 3'(selw_log + 3'h1);
   wire signed [3:0] wgmul_log = 4'(gmul_log + 4'sh1);

   // Operand fields
   wire [4:0] vd = inst_i.word[VD_LSB +: 5];
   wire masked = ~inst_i.word[MASK_FIELD_BIT];
   logic [4:0] s_reg [2];
   logic [2:0] s_opw [2];
   logic signed [3:0] s_opg [2];
   logic [2:0] d_opw;
   logic signed [3:0] d_opg;

   // Effective widths and groups per operand kind
   always_comb begin
      s_reg[0] = inst_i.word[VS1_LSB +: 5];
      s_reg[1] = inst_i.word[VS2_LSB +: 5];
      d_opw = selw_log;
      d_opg = gmul_log;
      s_opw[0] = selw_log;
      s_opw[1] = selw_log;
      s_opg[0] = gmul_log;
      s_opg[1] = gmul_log;
      case (inst_i.opk)
         OPK_PLAIN: begin
         end
         OPK_WIDEN: begin
            d_opw = wselw_log;
            d_opg = wgmul_log;
         end
         OPK_NARROW: begin
            s_opw[1] = wselw_log;
            s_opg[1] = wgmul_log;
         end
         OPK_WRED: begin
            d_opw = wselw_log;
            d_opg = 4'sh0;
            s_opw[0] = wselw_log;
            s_opg[0] = 4'sh0;
         end
         OPK_MASKDST: begin
            d_opw = MASK_OPW_LOG;
            d_opg = 4'sh0;
         end
         OPK_SCALARDST: begin
            d_opg = 4'sh0;
            s_opg[0] = 4'sh0;
         end
         default: begin
         end
      endcase
      for (int i = 0; i < 2; i++) begin
         if (inst_i.src_mask[i]) begin
            s_opw[i] = MASK_OPW_LOG;
            s_opg[i] = 4'sh0;
         end
      end
   end

   wire [4:0] nd = grp_n(d_opg);
   logic [1:0] src_bad_ov;
   logic [1:0] src_diff_ov;
   logic [1:0] src_misal;
   logic [1:0] src_big;
   logic [1:0] src_mask_mix;

   // Per-source checks against destination and mask register
   generate
      for (genvar s = 0; s < 2; s++) begin : g_src
         wire [4:0] ns = grp_n(s_opg[s]);
         wire ov = inst_i.vd_vec && inst_i.src_vec[s] && ovl(vd, nd, s_reg[s], ns);
         wire same = (d_opw == s_opw[s]);
         wire narrow_ok = (d_opw < s_opw[s]) && (vd == s_reg[s]);
         wire wide_ok = (d_opw > s_opw[s]) && !s_opg[s][3]
                        && (({1'b0, s_reg[s]} + {1'b0, ns}) == ({1'b0, vd} + {1'b0, nd}));
         assign src_bad_ov[s] = ov && !(same || narrow_ok || wide_ok);
         assign src_diff_ov[s] = ov && !same;
         assign src_misal[s] = inst_i.src_vec[s] && misal(s_reg[s], s_opg[s]);
         assign src_big[s] = inst_i.src_vec[s] && (s_opg[s] > MAX_GROUP_LOG);
         // Mask source is register zero at width one
         assign src_mask_mix[s] = masked && inst_i.src_vec[s] && (s_reg[s] == 5'h0)
                                  && (s_opw[s] != MASK_OPW_LOG);
      end
   endgenerate

   wire mixed_src = inst_i.src_vec[0] && inst_i.src_vec[1] && (s_opw[0] != s_opw[1])
                    && ovl(s_reg[0], grp_n(s_opg[0]), s_reg[1], grp_n(s_opg[1]));
   wire dst_misal = inst_i.vd_vec && misal(vd, d_opg);
   wire dst_big = inst_i.vd_vec && (d_opg > MAX_GROUP_LOG);
   wire mask_dst = (inst_i.opk == OPK_MASKDST);
   wire scal_dst = (inst_i.opk == OPK_SCALARDST) || (inst_i.opk == OPK_WRED);
   // Restart after a trap would reread a clobbered mask otherwise
   wire mask_ov = masked && inst_i.vd_vec && (vd == 5'h0) && !mask_dst && !scal_dst;
   wire [CAUSE_W-1:0] cause = {cfg_bad, mask_ov, |src_big | dst_big, |src_bad_ov,
                               |src_mask_mix | mixed_src, |src_misal | dst_misal};
   wire diff_ov = |(src_diff_ov & ~src_bad_ov);

   always_comb begin
      dec_next.valid = inst_i.valid;
      dec_next.illegal = inst_i.valid && (cause != '0);
      dec_next.cause = inst_i.valid ? cause : '0;
      dec_next.masked = masked;
      dec_next.tail_agn = ctrl_reg[CTRL_TA_BIT] || diff_ov || mask_dst;
      dec_next.mask_agn = ctrl_reg[CTRL_MA_BIT] || diff_ov;
      dec_next.mask_dst = mask_dst;
      dec_next.scal_dst = scal_dst;
      // Scalar register result never depends on the body being empty
      dec_next.xf_write = inst_i.valid && inst_i.writes_xf && (cause == '0);
   end

   // Element bounds
   wire [19:0] per_reg = 20'(REG_BITS) >> selw_log;
   wire [19:0] max_len = gmul_log[3] ? (per_reg >> 3'(-gmul_log)) : (per_reg << gmul_log[1:0]);
   wire [19:0] tail_bound = (max_len > per_reg) ? max_len : per_reg;
   wire [19:0] idx = 20'(elem_i.idx);
   wire [19:0] start_w = 20'(start_reg);
   wire [19:0] len_w = 20'(len_reg);
   wire body_live = start_w < len_w;
   wire in_pre = idx < start_w;
   wire in_body = !in_pre && (idx < len_w);
   wire in_tail = !in_pre && !in_body && (idx < tail_bound);
   wire mask_on = !dec_reg.masked || elem_i.mask_bit;
   wire scal_skip = dec_reg.scal_dst && (idx != 20'h0);
   wire tail_res = dec_reg.mask_dst && !elem_i.mask_load;

   always_comb begin
      elem_next.valid = elem_i.valid;
      elem_next.cls = CLS_BEYOND;
      elem_next.write_en = 1'b0;
      elem_next.write_ones = 1'b0;
      elem_next.write_result = 1'b0;
      elem_next.exc_en = 1'b0;
      if (in_pre) begin
         elem_next.cls = CLS_PRESTART;
      end else if (in_body && mask_on) begin
         elem_next.cls = CLS_ACTIVE;
         elem_next.write_en = !scal_skip;
         elem_next.write_result = !scal_skip;
         elem_next.exc_en = 1'b1;
      end else if (in_body) begin
         elem_next.cls = CLS_INACTIVE;
         elem_next.write_en = dec_reg.mask_agn && !scal_skip;
         elem_next.write_ones = dec_reg.mask_agn && !scal_skip;
      end else if (in_tail) begin
         elem_next.cls = CLS_TAIL;
         elem_next.write_en = dec_reg.tail_agn && !scal_skip;
         elem_next.write_result = dec_reg.tail_agn && tail_res && !scal_skip;
         elem_next.write_ones = dec_reg.tail_agn && !tail_res && !scal_skip;
      end
      if (!body_live || !elem_i.valid) begin
         elem_next.write_en = 1'b0;
         elem_next.write_ones = 1'b0;
         elem_next.write_result = 1'b0;
      end
      if (!elem_i.valid) begin
         elem_next.exc_en = 1'b0;
      end
   end

   // Bus slave: zero wait states, writes land in the data phase
   wire addr_ok = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
   wire addr_hit = (ahb_i.haddr[31:8] == 24'h0);
   wire [7:0] addr_lo = addr_hit ? ahb_i.haddr[7:0] : 8'hff;
   wire wr_ctrl = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
   wire wr_start = wr_pend_reg && (wr_addr_reg == OFS_START);
   wire wr_len = wr_pend_reg && (wr_addr_reg == OFS_LEN);
   assign ctrl_next = wr_ctrl ? hwdata_i[7:0] : ctrl_reg;
   assign start_next = wr_start ? hwdata_i[IDX_W-1:0] : start_reg;
   assign len_next = wr_len ? hwdata_i[IDX_W-1:0] : len_reg;
   assign illcnt_next = dec_next.illegal ? 32'(illcnt_reg + 32'h1) : illcnt_reg;
   // Reads see a write still in its data phase
   wire [31:0] rd_val =
      (addr_lo == OFS_CTRL) ? {24'h0, ctrl_next} :
      (addr_lo == OFS_START) ? {16'h0, start_next} :
      (addr_lo == OFS_LEN) ? {16'h0, len_next} :
      (addr_lo == OFS_STATUS) ? {25'h0, dec_reg.cause, dec_reg.illegal} :
      (addr_lo == OFS_ILLCNT) ? illcnt_reg : 32'h0;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= CTRL_RST;
         start_reg <= START_RST;
         len_reg <= LEN_RST;
         illcnt_reg <= ILLCNT_RST;
      end else begin
         ctrl_reg <= ctrl_next;
         start_reg <= start_next;
         len_reg <= len_next;
         illcnt_reg <= illcnt_next;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0;
         hreadyout_reg <= 1'b1;
      end else begin
         wr_pend_reg <= addr_ok && ahb_i.hwrite;
         wr_addr_reg <= addr_lo;
         hrdata_reg <= (addr_ok && !ahb_i.hwrite) ? rd_val : hrdata_reg;
         hreadyout_reg <= 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dec_reg <= '0;
         elem_reg <= '0;
      end else begin
         dec_reg <= dec_next;
         elem_reg <= elem_next;
      end
   end

   assign hrdata_o = hrdata_reg;
   assign hreadyout_o = hreadyout_reg;
   assign hresp_o = 1'b0;
   assign dec_o = dec_reg;
   assign elem_o = elem_reg;
endmodule : vomec_ctrl

// >>> tb/vomec_ctrl_monitor.sv
/*
 Checker for the vector operand, mask and element control block.
 Assumes it is bound to vomec_ctrl and sees only that module's ports.
*/
`timescale 1ns/100ps
module vomec_ctrl_monitor
   import vomec_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire vomec_pkg::vomec_inst_t inst_i,
   input wire vomec_pkg::vomec_elem_req_t elem_i,
   input wire vomec_pkg::vomec_dec_t dec_o,
   input wire vomec_pkg::vomec_elem_res_t elem_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_no_trap;
      elem_o.valid && elem_o.cls != CLS_ACTIVE |-> !elem_o.exc_en;
   endproperty
   a_no_trap: assert property (p_no_trap) else $error("trap on non-active element");
   property p_prestart;
      elem_o.valid && elem_o.cls == CLS_PRESTART |-> !elem_o.write_en && !elem_o.exc_en;
   endproperty
   a_prestart: assert property (p_prestart) else $error("prestart element touched");
   property p_active;
      elem_o.valid && elem_o.cls == CLS_ACTIVE
         |-> elem_o.exc_en && (elem_o.write_en || $past(dec_o.scal_dst));
   endproperty
   a_active: assert property (p_active) else $error("active element not enabled");
   property p_tail;
      elem_o.valid && elem_o.cls == CLS_TAIL
         |-> !elem_o.exc_en && (!elem_o.write_result || $past(dec_o.mask_dst));
   endproperty
   a_tail: assert property (p_tail) else $error("tail element misused");
   property p_mask_field;
      inst_i.valid |=> dec_o.valid && dec_o.masked == !$past(inst_i.word[MASK_FIELD_BIT]);
   endproperty
   a_mask_field: assert property (p_mask_field) else $error("mask field misread");
   property p_unmasked;
      elem_i.valid && dec_o.valid && !dec_o.masked |=> elem_o.cls != CLS_INACTIVE;
   endproperty
   a_unmasked: assert property (p_unmasked) else $error("unmasked element inactive");
   property p_mask_off;
      elem_i.valid && dec_o.masked && !elem_i.mask_bit |=> elem_o.cls != CLS_ACTIVE;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("masked-off element active");
   property p_illegal;
      dec_o.illegal |-> !dec_o.xf_write && dec_o.cause != '0;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal decode still writes");
   property p_mask_dst_ta;
      inst_i.valid && inst_i.opk == OPK_MASKDST |=> dec_o.illegal || dec_o.tail_agn;
   endproperty
   a_mask_dst_ta: assert property (p_mask_dst_ta) else $error("mask result not agnostic");
   property p_mask_reg_dest;
      inst_i.valid && !inst_i.word[MASK_FIELD_BIT] && inst_i.opk == OPK_PLAIN && inst_i.vd_vec
         && inst_i.word[11:7] == 5'h00 |=> dec_o.illegal && dec_o.cause[4];
   endproperty
   a_mask_reg_dest: assert property (p_mask_reg_dest) else $error("mask register overwrite accepted");
   c_tail: cover property (elem_o.valid && elem_o.cls == CLS_TAIL);
   c_inactive: cover property (elem_o.valid && elem_o.cls == CLS_INACTIVE);
   c_illegal: cover property (dec_o.illegal);
endmodule : vomec_ctrl_monitor

bind vomec_ctrl vomec_ctrl_monitor i_mon (
   .clock_i(clock_i),
   .rst_n_i(rst_n_i),
   .inst_i(inst_i),
   .elem_i(elem_i),
   .dec_o(dec_o),
   .elem_o(elem_o)
);

// >>> tb/tb_top.sv
/*
 Self-checking bench for vomec_ctrl: AHB-Lite register tasks, decode runs.
 Assumes a 20 MHz clock and the register offsets of vomec_pkg.
*/
`timescale 1ns/100ps
module tb_top;
   import vomec_pkg::*;
   logic clock_i;
   logic rst_n_i;
   logic a_sel;
   logic [31:0] a_addr;
   logic [1:0] a_trans;
   logic a_write;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic [31:0] rd;
   vomec_ahb_req_t ahb;
   vomec_inst_t inst;
   vomec_elem_req_t elem;
   vomec_dec_t dec;
   vomec_elem_res_t eo;
   vomec_dec_t dq;
   vomec_elem_res_t eq;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [15:0] t_idx [6] = '{16'd1, 16'd5, 16'd5, 16'd12, 16'd16, 16'd5};
   logic t_mb [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   logic t_mef [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   logic t_one [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   vomec_cls_t t_cls [6] = '{CLS_PRESTART, CLS_ACTIVE, CLS_INACTIVE, CLS_TAIL, CLS_BEYOND,
      CLS_ACTIVE};
   // Slave hreadyout is the bus hready; word transfers only
   assign ahb = {a_sel, a_addr, a_trans, a_write, 3'h2, hready};
   vomec_ctrl i_dut (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .ahb_i(ahb),
      .hwdata_i(hwdata),
      .inst_i(inst),
      .elem_i(elem),
      .hrdata_o(hrdata),
      .hreadyout_o(hready),
      .hresp_o(hresp),
      .dec_o(dec),
      .elem_o(eo)
   );
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Whole run is well under this; a stuck wait ends here
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task wait_rdy;
      @(posedge clock_i);
      while (hready !== 1'b1) @(posedge clock_i);
   endtask : wait_rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      a_sel <= 1'b1;
      a_addr <= {24'h0, a};
      a_trans <= HTRANS_NONSEQ;
      a_write <= w;
      wait_rdy();
      a_sel <= 1'b0;
      a_trans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   // Instruction held four edges so element answer sees its own decode;
   // the illegal counter therefore counts an illegal run four times
   task run(input vomec_opk_t k, input logic [4:0] vd, input logic [4:0] vs1,
      input logic [4:0] vs2, input logic mef, input logic [1:0] sv, input logic [1:0] sm,
      input logic xf, input logic [15:0] idx, input logic mb);
      inst <= '{1'b1, {6'h00, mef, vs2, vs1, 3'h0, vd, 7'h57}, k, k != OPK_SCALARDST, sv, sm, xf};
      @(posedge clock_i);
      elem <= '{1'b1, idx, mb, 1'b0};
      repeat (2) @(posedge clock_i);
      #1;
      dq = dec;
      eq = eo;
      @(posedge clock_i);
      inst.valid <= 1'b0;
      elem.valid <= 1'b0;
      @(posedge clock_i);
   endtask : run
   initial begin
      rst_n_i = 1'b0;
      a_sel = 1'b0;
      a_addr = 32'h0;
      a_trans = 2'h0;
      a_write = 1'b0;
      hwdata = 32'h0;
      inst = '0;
      elem = '0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      foreach (t_idx[i]) begin
         bus(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      chk(32'({hready, hresp}), 32'h2);
      $display("register reset values done");
      run(OPK_SCALARDST, 5'd0, 5'd0, 5'd4, 1'b1, 2'b10, 2'b00, 1'b1, 16'd0, 1'b1);
      chk(32'(dq.xf_write), 32'h1);
      chk(32'(eq.write_en), 32'h0);
      run(OPK_WIDEN, 5'd4, 5'd0, 5'd5, 1'b1, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.illegal), 32'h0);
      run(OPK_WIDEN, 5'd4, 5'd0, 5'd4, 1'b1, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.cause[2]), 32'h1);
      run(OPK_NARROW, 5'd4, 5'd0, 5'd4, 1'b1, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'({dq.illegal, dq.tail_agn, dq.mask_agn}), 32'h3);
      run(OPK_NARROW, 5'd5, 5'd0, 5'd4, 1'b1, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.cause[2]), 32'h1);
      run(OPK_PLAIN, 5'd8, 5'd2, 5'd2, 1'b1, 2'b11, 2'b01, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.cause[1]), 32'h1);
      run(OPK_PLAIN, 5'd0, 5'd0, 5'd4, 1'b0, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'({dq.masked, dq.cause[4]}), 32'h3);
      run(OPK_MASKDST, 5'd0, 5'd0, 5'd4, 1'b0, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'({dq.illegal, dq.tail_agn}), 32'h1);
      bus(1'b1, OFS_CTRL, 32'h01);
      run(OPK_PLAIN, 5'd3, 5'd0, 5'd4, 1'b1, 2'b10, 2'b00, 1'b1, 16'd0, 1'b1);
      chk(32'({dq.cause[0], dq.xf_write}), 32'h2);
      bus(1'b1, OFS_CTRL, 32'h02);
      run(OPK_WIDEN, 5'd0, 5'd0, 5'd8, 1'b1, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.illegal), 32'h0);
      bus(1'b1, OFS_CTRL, 32'h03);
      run(OPK_WIDEN, 5'd0, 5'd0, 5'd8, 1'b1, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.cause[3]), 32'h1);
      run(OPK_WRED, 5'd1, 5'd1, 5'd8, 1'b1, 2'b11, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.illegal), 32'h0);
      bus(1'b1, OFS_CTRL, 32'h04);
      run(OPK_PLAIN, 5'd8, 5'd0, 5'd4, 1'b1, 2'b10, 2'b00, 1'b0, 16'd0, 1'b1);
      chk(32'(dq.cause[5]), 32'h1);
      bus(1'b0, OFS_ILLCNT, 32'h0);
      chk(rd, 32'h1c);
      $display("decode legality done");
      bus(1'b1, OFS_CTRL, 32'hc0);
      bus(1'b1, OFS_START, 32'h2);
      bus(1'b1, OFS_LEN, 32'ha);
      foreach (t_idx[i]) begin
         run(OPK_PLAIN, 5'd8, 5'd0, 5'd4, t_mef[i], 2'b10, 2'b00, 1'b0, t_idx[i], t_mb[i]);
         chk(32'(eq.cls), 32'(t_cls[i]));
         chk(32'(eq.write_ones), 32'(t_one[i]));
         chk(32'(eq.exc_en), 32'(t_cls[i] == CLS_ACTIVE));
      end
      // Group of one half: tail reaches register bits over width, not the group size
      bus(1'b1, OFS_CTRL, 32'h07);
      bus(1'b1, OFS_LEN, 32'h6);
      run(OPK_PLAIN, 5'd8, 5'd0, 5'd4, 1'b0, 2'b10, 2'b00, 1'b0, 16'd12, 1'b1);
      chk(32'({eq.cls, eq.write_ones}), 32'({CLS_TAIL, 1'b0}));
      run(OPK_PLAIN, 5'd8, 5'd0, 5'd4, 1'b0, 2'b10, 2'b00, 1'b0, 16'd5, 1'b0);
      chk(32'({eq.write_en, eq.write_ones}), 32'h0);
      bus(1'b1, OFS_CTRL, 32'hc0);
      bus(1'b1, OFS_START, 32'ha);
      bus(1'b1, OFS_LEN, 32'ha);
      run(OPK_PLAIN, 5'd8, 5'd0, 5'd4, 1'b1, 2'b10, 2'b00, 1'b0, 16'd12, 1'b1);
      chk(32'({eq.write_en, eq.write_ones}), 32'h0);
      $display("element classes done");
      report_and_stop();
   end
endmodule : tb_top
